/* File: fast_count_pkg.sv */
// Constants and types shared by the fast-mode wrap counter design.
// Summary of operation
// - Up past all ones wraps to zero.
// - Down past zero wraps to all ones.
// - Aux input: off, input, gate, sync.
// - Gate opens on rise, closes on fall.
// - Without gate, counting runs immediately.
// - Gate reopening keeps the current count.
// - Sync rising edge loads start value.
// - Every rising sync edge reloads, not just first.
// - Input flag shows present aux level.
// - Feedback word: count, then seven flags.
// - Life bit inverts on every update.
// - Isochronous flag set when applied.
// - Group fault follows supply short live.
// - Parameter fault clears on valid set.
// - Direction flag one when count decreases.
// - Gate flag high while gate permits counting.
// - Four feedback bytes form one snapshot.
// - Selectable 2.5 or 25 us input filter.
// - Load value is the start value.
// - Report values valid at sampling instant.
// - No control word accepted from master.
package fast_count_pkg;

  localparam int COUNT_W = 25;
  localparam logic [31:0] FEEDBACK_OFFSET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 25'h000_0000;
  localparam logic [COUNT_W-1:0] LOAD_RESET = 25'h000_0000;

  // Feedback word field positions.
  localparam int COUNT_LSB = 0;
  localparam int GATE_BIT = 25;
  localparam int DIR_BIT = 26;
  localparam int INPUT_BIT = 27;
  localparam int GROUP_BIT = 28;
  localparam int PARAM_BIT = 29;
  localparam int ISO_BIT = 30;
  localparam int LIFE_BIT = 31;

  // Filter times in nanoseconds and the clock period they are counted in.
  localparam int CLOCK_NS = 25;
  localparam int FILTER_SHORT_NS = 2500;
  localparam int FILTER_LONG_NS = 25000;
  localparam int FILTER_SHORT_CYC = (FILTER_SHORT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int FILTER_LONG_CYC = (FILTER_LONG_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int FILTER_CNT_W = 10;
  localparam logic [FILTER_CNT_W-1:0] FILTER_SHORT_LIM = 10'(FILTER_SHORT_CYC - 1);
  localparam logic [FILTER_CNT_W-1:0] FILTER_LONG_LIM = 10'(FILTER_LONG_CYC - 1);

  // Function of the auxiliary input.
  typedef enum logic [1:0] {
    AUX_OFF = 2'h0,
    AUX_INPUT = 2'h1,
    AUX_GATE = 2'h2,
    AUX_SYNC = 2'h3
  } aux_input_function_t;

  // Parameter set assigned to the block.
  typedef struct packed {
    aux_input_function_t aux_input_function;
    logic gate_inverted;
    logic filter_long_count;
    logic filter_long_dir;
    logic filter_long_aux;
    logic dir_inverted;
    logic isochronous;
    logic [COUNT_W-1:0] load_value;
  } param_set_t;

  // Feedback word layout.
  typedef struct packed {
    logic life_toggle_bit;
    logic isochronous_applied_flag;
    logic parameter_fault_flag;
    logic group_fault_flag;
    logic input_level_flag;
    logic direction_flag;
    logic gate_open_flag;
    logic [COUNT_W-1:0] count;
  } feedback_word_t;

endpackage

/* File: input_filter.sv */
// Glitch filter with selectable settle time for one encoder input.
`timescale 1ns/10ps
module input_filter (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic long_sel,
  input wire logic raw,
  output logic filtered
);

  logic [fast_count_pkg::FILTER_CNT_W-1:0] stable_q;
  logic [fast_count_pkg::FILTER_CNT_W-1:0] limit;

  assign limit = long_sel ? fast_count_pkg::FILTER_LONG_LIM : fast_count_pkg::FILTER_SHORT_LIM;

  // A new level is accepted only after it has stood for the selected time.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stable_q <= '0;
      filtered <= 1'b0;
    end else if (raw == filtered) begin
      stable_q <= '0;
    end else if (stable_q >= limit) begin
      filtered <= raw;
      stable_q <= '0;
    end else begin
      stable_q <= stable_q + 1'b1;
    end
  end

endmodule // input_filter

/* File: wrap_counter.sv */
// Wrapping 25-bit up/down counter with load.
`timescale 1ns/10ps
module wrap_counter (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [fast_count_pkg::COUNT_W-1:0] load_value,
  input wire logic step,
  input wire logic down,
  output logic [fast_count_pkg::COUNT_W-1:0] count
);

  // Load wins over a step; the modulo add wraps in both directions.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= fast_count_pkg::COUNT_RESET;
    end else if (load) begin
      count <= load_value;
    end else if (step && down) begin
      count <= count - 1'b1;
    end else if (step) begin
      count <= count + 1'b1;
    end
  end

endmodule // wrap_counter

/* File: fast_count_top.sv */
// Fast-mode position counter producing a read-only feedback word.
`timescale 1ns/10ps
module fast_count_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic count_pin,
  input wire logic direction_pin,
  input wire logic aux_input_pin,
  input wire logic supply_short,
  input wire logic param_strobe,
  input wire fast_count_pkg::param_set_t param_in,
  input wire logic sample_strobe,
  output fast_count_pkg::feedback_word_t fast_count_feedback_word,
  output logic feedback_valid
);

  fast_count_pkg::param_set_t param_q;
  logic params_ok_q;
  logic param_fault_q;
  logic count_f;
  logic dir_f;
  logic aux_f;
  logic count_prev_q;
  logic aux_prev_q;
  logic gate_q;
  logic dir_q;
  logic step;
  logic down;
  logic load;
  logic aux_level;
  logic aux_rise;
  logic aux_fall;
  logic gate_open;
  logic param_bad;
  logic [fast_count_pkg::COUNT_W-1:0] count;

  // Parameter check: gate inversion only makes sense with the gate function.
  assign param_bad = param_in.gate_inverted &&
                     (param_in.aux_input_function != fast_count_pkg::AUX_GATE);

  // Only well-formed parameter sets are accepted; a bad one flags a fault.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      param_q <= '0;
      params_ok_q <= 1'b0;
      param_fault_q <= 1'b0;
    end else if (param_strobe) begin
      param_fault_q <= param_bad;
      params_ok_q <= !param_bad;
      if (!param_bad) begin
        param_q <= param_in;
      end
    end
  end

  // Input filters on count, direction and auxiliary pins.
  input_filter u_filt_count (
    .clock(clock),
    .reset_n(reset_n),
    .long_sel(param_q.filter_long_count),
    .raw(count_pin),
    .filtered(count_f)
  );
  input_filter u_filt_dir (
    .clock(clock),
    .reset_n(reset_n),
    .long_sel(param_q.filter_long_dir),
    .raw(direction_pin),
    .filtered(dir_f)
  );
  input_filter u_filt_aux (
    .clock(clock),
    .reset_n(reset_n),
    .long_sel(param_q.filter_long_aux),
    .raw(aux_input_pin),
    .filtered(aux_f)
  );

  // Edge history of the filtered count and auxiliary inputs.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_prev_q <= 1'b0;
      aux_prev_q <= 1'b0;
    end else begin
      count_prev_q <= count_f;
      aux_prev_q <= aux_level;
    end
  end

  // Gate input may be inverted; an unused input reads low.
  assign aux_level = (param_q.aux_input_function == fast_count_pkg::AUX_OFF) ? 1'b0 :
                     (aux_f ^ (param_q.gate_inverted &&
                      param_q.aux_input_function == fast_count_pkg::AUX_GATE));
  assign aux_rise = aux_level && !aux_prev_q;
  assign aux_fall = !aux_level && aux_prev_q;

  // Gate state follows aux edges only in gate mode, so an open gate left over from
  // another mode cannot count without a fresh edge; opening never reloads the count.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b0;
    end else if (param_q.aux_input_function != fast_count_pkg::AUX_GATE) begin
      gate_q <= 1'b0;
    end else if (aux_rise) begin
      gate_q <= 1'b1;
    end else if (aux_fall) begin
      gate_q <= 1'b0;
    end
  end

  // Counting runs freely once valid parameters are held, unless the gate function is chosen.
  always_comb begin
    unique case (param_q.aux_input_function)
      fast_count_pkg::AUX_GATE: gate_open = gate_q && params_ok_q;
      fast_count_pkg::AUX_OFF,
      fast_count_pkg::AUX_INPUT,
      fast_count_pkg::AUX_SYNC: gate_open = params_ok_q;
    endcase
  end

  // One count step per rising count edge while the gate is open.
  assign step = gate_open && count_f && !count_prev_q;
  assign down = dir_f ^ param_q.dir_inverted;

  // Load on parameter acceptance and on every rising sync edge.
  assign load = (param_strobe && !param_bad) ||
                (params_ok_q && aux_rise &&
                 param_q.aux_input_function == fast_count_pkg::AUX_SYNC);

  wrap_counter u_counter (
    .clock(clock),
    .reset_n(reset_n),
    .load(load),
    .load_value(param_strobe ? param_in.load_value : param_q.load_value),
    .step(step),
    .down(down),
    .count(count)
  );

  // Direction of the last change; a wrap keeps the direction of its step.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dir_q <= 1'b0;
    end else if (step) begin
      dir_q <= down;
    end
  end

  // Whole-word snapshot on each sample strobe; the life bit inverts each time.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fast_count_feedback_word <= '0;
      feedback_valid <= 1'b0;
    end else begin
      feedback_valid <= sample_strobe;
      if (sample_strobe) begin
        fast_count_feedback_word.count <= count;
        fast_count_feedback_word.gate_open_flag <= gate_open;
        fast_count_feedback_word.direction_flag <= dir_q;
        fast_count_feedback_word.input_level_flag <= aux_f;
        fast_count_feedback_word.group_fault_flag <= supply_short;
        fast_count_feedback_word.parameter_fault_flag <= param_fault_q;
        fast_count_feedback_word.isochronous_applied_flag <=
          param_q.isochronous && params_ok_q;
        fast_count_feedback_word.life_toggle_bit <=
          !fast_count_feedback_word.life_toggle_bit;
      end
    end
  end

  // Checks kept next to the logic.
  a_life_toggles: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> fast_count_feedback_word.life_toggle_bit !=
                      $past(fast_count_feedback_word.life_toggle_bit))
    else $error("life bit did not toggle");
  a_snapshot_count: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> fast_count_feedback_word.count == $past(count))
    else $error("snapshot count mismatch");
  a_word_holds: assert property (@(posedge clock) disable iff (!reset_n)
    !sample_strobe |=> $stable(fast_count_feedback_word))
    else $error("feedback changed without sample");
  a_up_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    (step && !down && !load && count == 25'h1FF_FFFF) |=> count == 25'h000_0000)
    else $error("up wrap failed");
  a_down_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    (step && down && !load && count == 25'h000_0000) |=> count == 25'h1FF_FFFF)
    else $error("down wrap failed");
  a_sync_load: assert property (@(posedge clock) disable iff (!reset_n)
    (params_ok_q && aux_rise && !param_strobe &&
     param_q.aux_input_function == fast_count_pkg::AUX_SYNC)
    |=> count == $past(param_q.load_value))
    else $error("sync did not reload");
  a_gate_closed_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (param_q.aux_input_function == fast_count_pkg::AUX_GATE && !gate_q &&
     !aux_rise && !param_strobe) |=> $stable(count))
    else $error("counted with gate closed");
  a_param_fault: assert property (@(posedge clock) disable iff (!reset_n)
    param_strobe |=> param_fault_q == $past(param_bad))
    else $error("parameter fault wrong");
  a_group_fault: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> fast_count_feedback_word.group_fault_flag == $past(supply_short))
    else $error("group fault not live");
  a_count_down: assert property (@(posedge clock) disable iff (!reset_n)
    (step && down && !load) |=> count == $past(count) - 25'h000_0001)
    else $error("down step wrong");
  a_count_up: assert property (@(posedge clock) disable iff (!reset_n)
    (step && !down && !load) |=> count == $past(count) + 25'h000_0001)
    else $error("up step wrong");
  a_valid_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> feedback_valid)
    else $error("valid missing after sample");
  a_valid_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !sample_strobe |=> !feedback_valid)
    else $error("valid without sample");
  a_input_flag: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> fast_count_feedback_word.input_level_flag == $past(aux_f))
    else $error("input flag wrong");
  a_idle_no_count: assert property (@(posedge clock) disable iff (!reset_n)
    (!params_ok_q && !load) |=> $stable(count))
    else $error("counted without valid parameters");
  a_gate_flag_bad: assert property (@(posedge clock) disable iff (!reset_n)
    (sample_strobe && !params_ok_q) |=> !fast_count_feedback_word.gate_open_flag)
    else $error("gate flag set without valid parameters");

  c_up_wrap: cover property (@(posedge clock) disable iff (!reset_n)
    step && !down && count == 25'h1FF_FFFF);
  c_sync_load: cover property (@(posedge clock) disable iff (!reset_n)
    load && !param_strobe);
  c_gate_reopen: cover property (@(posedge clock) disable iff (!reset_n)
    aux_fall ##[1:50] aux_rise);
  c_down_wrap: cover property (@(posedge clock) disable iff (!reset_n)
    step && down && count == 25'h000_0000);
  c_bad_params: cover property (@(posedge clock) disable iff (!reset_n)
    param_strobe && param_bad);

endmodule // fast_count_top

/* File: bus_master.sv */
// Fieldbus master model that samples the feedback word once per bus cycle.
`timescale 1ns/10ps
module bus_master (
  input wire logic clock,
  input wire fast_count_pkg::feedback_word_t fast_count_feedback_word,
  input wire logic feedback_valid,
  output logic sample_strobe,
  output logic [31:0] last_word,
  output logic got_valid
);
  // The strobe stays low between bus cycles.
  initial begin
    sample_strobe = 1'b0;
    last_word = 32'h0000_0000;
    got_valid = 1'b0;
  end
  // One bus cycle: strobe for one edge, then take the word in the cycle it is flagged valid.
  task automatic bus_cycle();
    @(posedge clock);
    sample_strobe <= 1'b1;
    @(posedge clock);
    sample_strobe <= 1'b0;
    // The valid pulse stands for one cycle only, so it is taken mid-cycle while it is high.
    @(negedge clock);
    got_valid = feedback_valid;
    last_word = fast_count_feedback_word;
    @(posedge clock);
  endtask
endmodule // bus_master

/* File: fast_count_top_bench.sv */
// Self-checking bench for the fast-mode wrap counter.
`timescale 1ns/10ps
module fast_count_top_bench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic count_pin = 1'b0;
  logic direction_pin = 1'b0;
  logic aux_input_pin = 1'b0;
  logic supply_short = 1'b0;
  logic param_strobe = 1'b0;
  fast_count_pkg::param_set_t param_in = '0;
  logic sample_strobe;
  fast_count_pkg::feedback_word_t word;
  logic feedback_valid;
  logic [31:0] w;
  logic got_valid;
  logic prev_life = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  // The clock runs at 40 MHz.
  always #12.5 clock = ~clock;
  fast_count_top DUT (.clock(clock), .reset_n(reset_n), .count_pin(count_pin),
    .direction_pin(direction_pin), .aux_input_pin(aux_input_pin),
    .supply_short(supply_short), .param_strobe(param_strobe), .param_in(param_in),
    .sample_strobe(sample_strobe), .fast_count_feedback_word(word),
    .feedback_valid(feedback_valid));
  bus_master MASTER (.clock(clock), .fast_count_feedback_word(word),
    .feedback_valid(feedback_valid), .sample_strobe(sample_strobe), .last_word(w),
    .got_valid(got_valid));
  // Compares one value and counts the result.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Runs one bus cycle and checks the valid pulse and the life bit.
  task automatic poll();
    MASTER.bus_cycle();
    check("valid", {31'h0, got_valid}, 32'h1);
    check("life", {31'h0, w[31]}, {31'h0, ~prev_life});
    prev_life = w[31];
  endtask
  // Polls and checks count, gate, direction and input level fields.
  task automatic expect_fields(input logic [24:0] c, input logic g, input logic d,
      input logic i);
    poll();
    check("count", {7'h00, w[24:0]}, {7'h00, c});
    check("gate", {31'h0, w[25]}, {31'h0, g});
    check("dir", {31'h0, w[26]}, {31'h0, d});
    check("input", {31'h0, w[27]}, {31'h0, i});
  endtask
  // Assigns one parameter set with a single strobe.
  task automatic setp(input fast_count_pkg::aux_input_function_t f, input logic gi,
      input logic fl, input logic iso, input logic [24:0] ld);
    @(posedge clock);
    param_strobe <= 1'b1;
    param_in <= '{f, gi, fl, 1'b0, 1'b0, 1'b0, iso, ld};
    @(posedge clock);
    param_strobe <= 1'b0;
  endtask
  // One count pulse, each level held past the short filter time.
  task automatic step(input logic dn);
    direction_pin <= dn;
    repeat (110) @(posedge clock);
    count_pin <= 1'b1;
    repeat (110) @(posedge clock);
    count_pin <= 1'b0;
    repeat (110) @(posedge clock);
  endtask
  // Moves the auxiliary input and lets the filter settle.
  task automatic set_aux(input logic lvl);
    aux_input_pin <= lvl;
    repeat (110) @(posedge clock);
  endtask
  // Free counting from zero wraps both ways.
  task automatic t_wrap();
    setp(fast_count_pkg::AUX_OFF, 1'b0, 1'b0, 1'b0, 25'h000_0000);
    expect_fields(25'h000_0000, 1'b1, 1'b0, 1'b0);
    step(1'b1);
    expect_fields(25'h1FF_FFFF, 1'b1, 1'b1, 1'b0);
    step(1'b0);
    expect_fields(25'h000_0000, 1'b1, 1'b0, 1'b0);
    $display("TB: wrap test done");
  endtask
  // The input gate blocks counting while low and resumes without reload.
  task automatic t_gate();
    setp(fast_count_pkg::AUX_GATE, 1'b0, 1'b0, 1'b0, 25'h000_0005);
    step(1'b0);
    expect_fields(25'h000_0005, 1'b0, 1'b0, 1'b0);
    set_aux(1'b1);
    step(1'b0);
    expect_fields(25'h000_0006, 1'b1, 1'b0, 1'b1);
    set_aux(1'b0);
    step(1'b0);
    set_aux(1'b1);
    expect_fields(25'h000_0006, 1'b1, 1'b0, 1'b1);
    set_aux(1'b0);
    $display("TB: gate test done");
  endtask
  // Every rising reference edge reloads the start value.
  task automatic t_sync();
    setp(fast_count_pkg::AUX_SYNC, 1'b0, 1'b0, 1'b0, 25'h000_000A);
    step(1'b0);
    expect_fields(25'h000_000B, 1'b1, 1'b0, 1'b0);
    set_aux(1'b1);
    expect_fields(25'h000_000A, 1'b1, 1'b0, 1'b1);
    step(1'b0);
    set_aux(1'b0);
    set_aux(1'b1);
    expect_fields(25'h000_000A, 1'b1, 1'b0, 1'b1);
    set_aux(1'b0);
    $display("TB: sync test done");
  endtask
  // The long filter ignores a pulse shorter than 25 us.
  task automatic t_filter();
    setp(fast_count_pkg::AUX_OFF, 1'b0, 1'b1, 1'b0, 25'h000_0003);
    count_pin <= 1'b1;
    repeat (500) @(posedge clock);
    count_pin <= 1'b0;
    repeat (1100) @(posedge clock);
    expect_fields(25'h000_0003, 1'b1, 1'b0, 1'b0);
    count_pin <= 1'b1;
    repeat (1100) @(posedge clock);
    count_pin <= 1'b0;
    repeat (1100) @(posedge clock);
    expect_fields(25'h000_0004, 1'b1, 1'b0, 1'b0);
    $display("TB: filter test done");
  endtask
  // Fault, parameter and isochronous flags follow their causes.
  task automatic t_faults();
    setp(fast_count_pkg::AUX_INPUT, 1'b0, 1'b0, 1'b1, 25'h000_0000);
    supply_short <= 1'b1;
    set_aux(1'b1);
    expect_fields(25'h000_0000, 1'b1, 1'b0, 1'b1);
    check("flags", {29'h0, w[30:28]}, 32'h5);
    supply_short <= 1'b0;
    setp(fast_count_pkg::AUX_INPUT, 1'b1, 1'b0, 1'b0, 25'h000_0000);
    poll();
    check("flags", {29'h0, w[30:28]}, 32'h2);
    check("gate", {31'h0, w[25]}, 32'h0);
    setp(fast_count_pkg::AUX_INPUT, 1'b0, 1'b0, 1'b0, 25'h000_0000);
    poll();
    check("flags", {29'h0, w[30:28]}, 32'h0);
    $display("TB: fault test done");
  endtask
  // An inverted gate opens on a falling pin and an inverted direction counts down.
  task automatic t_invert();
    @(posedge clock);
    param_strobe <= 1'b1;
    param_in <= '{fast_count_pkg::AUX_GATE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 25'h000_0007};
    @(posedge clock);
    param_strobe <= 1'b0;
    step(1'b0);
    expect_fields(25'h000_0007, 1'b0, 1'b0, 1'b1);
    set_aux(1'b0);
    step(1'b0);
    expect_fields(25'h000_0006, 1'b1, 1'b1, 1'b0);
    $display("TB: invert test done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("TB: %0d checks, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence after a three-cycle reset.
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_wrap();
    t_gate();
    t_sync();
    t_filter();
    t_faults();
    t_invert();
    tally_and_finish();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule // fast_count_top_bench
